/* File: bench/testbench.sv */
// self-checking bench for the branch and increment execute block
// assumes bie_exec alone, file read data driven by the bench
`timescale 1ns/1ps
module testbench;
   import bie_pkg::*;
   logic               clk;
   logic               rst;
   logic [INSTR_W-1:0] instrWord;
   logic               instrValid;
   logic [DATA_W-1:0]  statusIn;
   logic [DATA_W-1:0]  fileRdData;
   logic [FADDR_W-1:0] fileRdAddr;
   logic [FADDR_W-1:0] fileWrAddr;
   logic [DATA_W-1:0]  fileWrData;
   logic               fileWrEn;
   logic [DATA_W-1:0]  accumulator;
   logic [PC_W-1:0]    programCounter;
   logic               pcLoad;
   logic               zeroFlag;
   logic               zeroWrEn;
   logic               flushFetch;
   logic               busy;
   int                 num_errors = 0;
   int                 comparisons = 0;
   bie_exec u_dut (.clk(clk), .rst(rst), .instrWord(instrWord),
      .instrValid(instrValid), .statusIn(statusIn),
      .fileRdAddr(fileRdAddr), .fileRdData(fileRdData),
      .fileWrAddr(fileWrAddr), .fileWrData(fileWrData),
      .fileWrEn(fileWrEn), .accumulator(accumulator),
      .programCounter(programCounter), .pcLoad(pcLoad),
      .zeroFlag(zeroFlag), .zeroWrEn(zeroWrEn),
      .flushFetch(flushFetch), .busy(busy));
   ////////////////////////////////////////////////////////////////////////
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // word w is taken at the next edge, nw sits in the following slot
   task automatic issue(input logic [11:0] w, input logic [7:0] f,
                        input logic [11:0] nw, input logic nv);
      @(posedge clk);
      instrWord <= w;
      instrValid <= 1'b1;
      fileRdData <= f;
      @(posedge clk);
      instrWord <= nw;
      instrValid <= nv;
      #1;
   endtask
   task automatic step();
      @(posedge clk);
      instrValid <= 1'b0;
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // outputs clear after reset; a reset inside the flushed slot ends it
   task automatic test_reset();
      step();
      check({pcLoad, fileWrEn, zeroWrEn, zeroFlag, busy}, 5'h00);
      check(accumulator, 8'h00);
      check(programCounter, 11'h000);
      @(posedge clk);
      instrWord <= {BRANCH_OP, 9'h0F0};
      instrValid <= 1'b1;
      @(posedge clk);
      rst <= 1'b1;
      #1;
      check({pcLoad, busy}, 2'b11);
      check(programCounter, {2'b10, 9'h0F0});
      step();
      check({pcLoad, busy, flushFetch}, 3'h0);
      check(programCounter, 11'h000);
      @(posedge clk);
      rst <= 1'b0;
      $display("test reset done");
   endtask
   // the slot after a branch carries an increment that must be dropped
   task automatic test_branch();
      issue({BRANCH_OP, 9'h1A5}, 8'h00, {INC_OP, 1'b0, 5'h03}, 1'b1);
      check(pcLoad, 1'b1);
      check(programCounter, {2'b10, 9'h1A5});
      check(flushFetch, 1'b1);
      check(busy, 1'b1);
      check(zeroWrEn, 1'b0);
      step();
      check(accumulator, 8'h00);
      check({pcLoad, flushFetch, zeroWrEn, fileWrEn}, 4'h0);
      check(busy, 1'b0);
      $display("test branch done");
   endtask
   // both destinations, with and without wrap to zero
   task automatic test_inc();
      logic [7:0] f;
      for (int i = 0; i < 4; i++) begin
         f = i[1] ? 8'hFF : 8'h7E;
         issue({INC_OP, i[0], 5'h13}, f, {INC_OP, i[0], 5'h13}, 1'b0);
         check(fileRdAddr, 5'h13);
         check(fileWrEn, i[0]);
         check(zeroWrEn, 1'b1);
         check(zeroFlag, i[1]);
         if (i[0]) begin
            check({fileWrAddr, fileWrData}, {5'h13, f + 8'h01});
         end else begin
            check(accumulator, 8'(f + 8'h01));
         end
      end
      $display("test increment done");
   endtask
   // zero result skips the slot, non-zero runs the next word at once
   task automatic test_skip();
      issue({INC_SKIP_OP, 1'b1, 5'h04}, 8'hFF, {BRANCH_OP, 9'h000}, 1'b1);
      check({fileWrEn, fileWrData}, 9'h100);
      check({zeroWrEn, flushFetch}, 2'b01);
      step();
      check({pcLoad, fileWrEn, accumulator}, 10'h000);
      issue({INC_SKIP_OP, 1'b0, 5'h04}, 8'h10, {INC_OP, 1'b1, 5'h04}, 1'b1);
      check(accumulator, 8'h11);
      check({zeroWrEn, flushFetch}, 2'b00);
      check(zeroFlag, 1'b1);
      step();
      check({fileWrEn, fileWrData, zeroWrEn}, 10'h223);
      $display("test skip done");
   endtask
   // decrement-skip and move patterns are not ours
   task automatic test_foreign();
      issue(12'h2C4, 8'h05, 12'h204, 1'b1);
      check({pcLoad, fileWrEn, zeroWrEn, busy}, 4'h0);
      step();
      check({pcLoad, fileWrEn, zeroWrEn, accumulator}, 11'h011);
      $display("test foreign done");
   endtask
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // reset, then the scenarios in turn
   initial begin
      rst = 1'b1;
      instrWord = 12'h000;
      instrValid = 1'b0;
      statusIn = 8'h4F;
      fileRdData = 8'h00;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      test_reset();
      test_branch();
      test_inc();
      test_skip();
      test_foreign();
      give_verdict();
   end
endmodule // testbench

/* File: hdl/bie_exec.sv */
// execute stage for absolute branch, increment and increment-skip
// assumes the core presents one instruction per clk with instrValid and
// provides a combinational read port into its file register array
`timescale 1ns/1ps
module bie_exec
   import bie_pkg::*;
(
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst,
   // instruction in
   input  wire logic [bie_pkg::INSTR_W-1:0]  instrWord,
   input  wire logic                         instrValid,
   input  wire logic [bie_pkg::DATA_W-1:0]   statusIn,
   // file register read port
   output logic      [bie_pkg::FADDR_W-1:0]  fileRdAddr,
   input  wire logic [bie_pkg::DATA_W-1:0]   fileRdData,
   // file register write port
   output logic      [bie_pkg::FADDR_W-1:0]  fileWrAddr,
   output logic      [bie_pkg::DATA_W-1:0]   fileWrData,
   output logic                              fileWrEn,
   // core state
   output logic      [bie_pkg::DATA_W-1:0]   accumulator,
   output logic      [bie_pkg::PC_W-1:0]     programCounter,
   output logic                              pcLoad,
   output logic                              zeroFlag,
   output logic                              zeroWrEn,
   output logic                              flushFetch,
   output logic                              busy
);
   import bie_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // decode
   logic                isBranch;
   logic                isInc;
   logic                isIncSkip;
   logic [DATA_W-1:0]   incResult;
   logic                resultZero;
   bie_state_t          state_reg;
   bie_state_t          state_next;
   logic                execOk;

   // top six opcode bits, shared by the two increment decoders
   function automatic logic [5:0] opTop6(input logic [INSTR_W-1:0] word);
      return word[INSTR_W-1 -: 6];
   endfunction

   // a flushed slot executes as a no-op, so nothing decodes there
   assign execOk    = instrValid && (state_reg == BIE_RUN);
   assign isBranch  = execOk &&
                      (instrWord[INSTR_W-1 -: 3] == BRANCH_OP);
   assign isInc     = execOk &&
                      (opTop6(instrWord) == INC_OP);
   assign isIncSkip = execOk &&
                      (opTop6(instrWord) == INC_SKIP_OP);
   assign fileRdAddr = instrWord[FADDR_W-1:0];
   // 8-bit sum drops the carry, giving modulo 256
   assign incResult  = fileRdData + INC_STEP;
   assign resultZero = (incResult == '0);

   ////////////////////////////////////////////////////////////////////////
   // cycle sequencing: a second slot for taken branches and skips
   always_comb begin
      state_next = BIE_RUN;
      case (state_reg)
         BIE_RUN: begin
            if (isBranch || (isIncSkip && resultZero)) begin
               state_next = BIE_FLUSH;
            end
         end
         BIE_FLUSH: state_next = BIE_RUN;
         default:   state_next = BIE_RUN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= BIE_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   assign busy       = (state_reg == BIE_FLUSH);
   assign flushFetch = busy;

   ////////////////////////////////////////////////////////////////////////
   // program counter load
   always_ff @(posedge clk) begin
      if (rst) begin
         programCounter <= PC_RESET;
         pcLoad         <= 1'b0;
      end else begin
         pcLoad <= isBranch;
         if (isBranch) begin
            programCounter <= {statusIn[PAGE_HI:PAGE_LO],
                               instrWord[LIT_W-1:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result writeback: accumulator or file register
   always_ff @(posedge clk) begin
      if (rst) begin
         accumulator <= ACC_RESET;
         fileWrEn    <= 1'b0;
         fileWrAddr  <= '0;
         fileWrData  <= '0;
      end else begin
         fileWrEn <= 1'b0;
         if (isInc || isIncSkip) begin
            if (instrWord[DEST_BIT]) begin
               fileWrEn   <= 1'b1;
               fileWrAddr <= instrWord[FADDR_W-1:0];
               fileWrData <= incResult;
            end else begin
               accumulator <= incResult;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // zero flag: only the plain increment touches it
   always_ff @(posedge clk) begin
      if (rst) begin
         zeroFlag <= 1'b0;
         zeroWrEn <= 1'b0;
      end else begin
         zeroWrEn <= isInc;
         if (isInc) begin
            zeroFlag <= resultZero;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks: expected values rebuilt from the raw word, statusIn and read data
   chk_branch_target: assert property (@(posedge clk) disable iff (rst)
      isBranch |=> programCounter ==
         {$past(statusIn[6:5]), $past(instrWord[8:0])} && pcLoad)
      else $error("branch target wrong");

   chk_branch_page: assert property (@(posedge clk) disable iff (rst)
      isBranch |=> programCounter[10:9] == $past(statusIn[6:5]))
      else $error("branch page bits wrong");

   chk_branch_flush: assert property (@(posedge clk) disable iff (rst)
      isBranch |=> flushFetch ##1 !flushFetch)
      else $error("branch not two cycles");

   chk_branch_flags: assert property (@(posedge clk) disable iff (rst)
      isBranch |=> !zeroWrEn && !fileWrEn)
      else $error("branch touched state");

   chk_inc_acc: assert property (@(posedge clk) disable iff (rst)
      (isInc || isIncSkip) && !instrWord[5] |=>
         accumulator == $past(fileRdData) + 8'h01 && !fileWrEn)
      else $error("accumulator result wrong");

   chk_inc_file: assert property (@(posedge clk) disable iff (rst)
      (isInc || isIncSkip) && instrWord[5] |=>
         fileWrEn && fileWrData == $past(fileRdData) + 8'h01 &&
         fileWrAddr == $past(instrWord[4:0]))
      else $error("file writeback wrong");

   chk_inc_zero: assert property (@(posedge clk) disable iff (rst)
      isInc |=> zeroWrEn && zeroFlag == ($past(fileRdData) == 8'hFF))
      else $error("zero flag wrong");

   chk_skip_taken: assert property (@(posedge clk) disable iff (rst)
      isIncSkip && fileRdData == 8'hFF |=> flushFetch && !zeroWrEn)
      else $error("skip not taken");

   chk_skip_cycles: assert property (@(posedge clk) disable iff (rst)
      isIncSkip && fileRdData != 8'hFF |=> !flushFetch && !zeroWrEn)
      else $error("skip taken wrongly");

   // the skip variant must never disturb the held zero flag
   chk_skip_flags: assert property (@(posedge clk) disable iff (rst)
      isIncSkip |=> $stable(zeroFlag) && !zeroWrEn)
      else $error("skip changed zero flag");

   // decode judged by what comes out, not by the internal strobes
   chk_decode_op: assert property (@(posedge clk) disable iff (rst)
      instrValid && !busy && instrWord[11:6] == 6'h0A |=>
         zeroWrEn && fileWrEn == $past(instrWord[5]))
      else $error("increment not decoded");

   chk_decode_skip: assert property (@(posedge clk) disable iff (rst)
      instrValid && !busy && instrWord[11:6] == 6'h0F |=>
         !zeroWrEn && fileWrEn == $past(instrWord[5]))
      else $error("skip increment not decoded");

   chk_decode_br: assert property (@(posedge clk) disable iff (rst)
      instrValid && !busy && instrWord[11:9] == 3'h5 |=>
         pcLoad && !fileWrEn)
      else $error("branch not decoded");

   // words outside the three opcodes raise no pcLoad, fileWrEn, zeroWrEn or busy and leave the accumulator alone
   chk_no_decode: assert property (@(posedge clk) disable iff (rst)
      instrValid && !busy && instrWord[11:9] != 3'h5 &&
      instrWord[11:6] != 6'h0A && instrWord[11:6] != 6'h0F |=>
         !pcLoad && !fileWrEn && !zeroWrEn && !busy &&
         $stable(accumulator))
      else $error("foreign word changed state");

   // the slot after a branch or a taken skip must act as a no-op
   chk_flush_noop: assert property (@(posedge clk) disable iff (rst)
      busy |=> !pcLoad && !fileWrEn && !zeroWrEn && !busy &&
         $stable(accumulator))
      else $error("flushed slot executed");

endmodule // bie_exec

/* File: hdl/bie_pkg.sv */
// constants for the branch and increment execute block
// assumes a 12-bit instruction word and an 8-bit data path
package bie_pkg;
   localparam int INSTR_W     = 12;
   localparam int DATA_W      = 8;
   localparam int PC_W        = 11;
   localparam int FADDR_W     = 5;
   localparam int LIT_W       = 9;
   // absolute branch: top three bits
   localparam logic [2:0] BRANCH_OP     = 3'h5;
   // increment patterns: top six bits
   localparam logic [5:0] INC_OP        = 6'h0A;
   localparam logic [5:0] INC_SKIP_OP   = 6'h0F;
   // field positions
   localparam int DEST_BIT    = 5;
   localparam int PAGE_HI     = 6;
   localparam int PAGE_LO     = 5;
   // reset values and increment step
   localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
   localparam logic [PC_W-1:0]   PC_RESET   = 11'h000;
   localparam logic [DATA_W-1:0] INC_STEP   = 8'h01;
   typedef enum logic [0:0] {
      BIE_RUN   = 1'b0,
      BIE_FLUSH = 1'b1
   } bie_state_t;
endpackage
